// ---- include/dual_dac_pkg.sv ----
package dual_dac_pkg;

    // ------------------------------------------------------------
    // bus addressing
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_UPPER = 6'b00_0110; // fixed upper six address bits
    localparam int unsigned BYTE_BITS = 8; // data bits per bus byte
    localparam logic [3:0] LAST_BIT_CNT = 4'h8; // count after the eighth rising edge

    // ------------------------------------------------------------
    // pointer byte fields
    // ------------------------------------------------------------
    localparam int unsigned PTR_CH_A = 0; // channel a select position
    localparam int unsigned PTR_CH_B = 1; // channel b select position
    localparam int unsigned NUM_CH = 2; // channels in the device

    // ------------------------------------------------------------
    // data word layout
    // ------------------------------------------------------------
    localparam int unsigned WORD_BITS = 16; // width of the data word
    localparam int unsigned POWER_MODE_HI = 15; // upper power mode bit
    localparam int unsigned POWER_MODE_LO = 14; // lower power mode bit
    localparam int unsigned CLEAR_ALL_N = 13; // clear all, active low
    localparam int unsigned SIMULTANEOUS_LOAD_N = 12; // simultaneous load, active low
    localparam int unsigned CODE_MSB = 11; // top bit of the left-justified code
    localparam int unsigned CODE_FIELD = 12; // room for the converter code
    localparam logic [15:0] READBACK_DEFAULT = 16'h2000; // power-on readback word

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    localparam logic [1:0] PM_NORMAL = 2'h0; // amplifier drives the output
    localparam logic [1:0] PM_1K = 2'h1; // 1 kohm to ground
    localparam logic [1:0] PM_100K = 2'h2; // 100 kohm to ground
    localparam logic [1:0] PM_OPEN = 2'h3; // output three-stated

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 20000; // 50 MHz system clock
    localparam int unsigned EXIT_TIME_PS = 2500; // power-down exit, in ns
    localparam int unsigned EXIT_CYCLES = (EXIT_TIME_PS * 1000) / CLK_PERIOD_PS; // rounds down
    localparam int unsigned EXIT_CNT_W = 8; // width of the wake counter

    // ------------------------------------------------------------
    // bus engine states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ACK = 8'h04,
        ST_PTR = 8'h08,
        ST_WR = 8'h10,
        ST_RD = 8'h20,
        ST_RD_ACK = 8'h40,
        ST_IGNORE = 8'h80
    } bus_state_t;

endpackage : dual_dac_pkg

// ---- hw/dual_dac_serial_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module dual_dac_serial_control
    import dual_dac_pkg::*;
#(
    parameter int unsigned DATA_BITS = 12 // converter resolution
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic address_select_pin_in,
    output logic [DATA_BITS-1:0] dac_a_code_out,
    output logic [DATA_BITS-1:0] dac_b_code_out,
    output logic [1:0] power_mode_a_out,
    output logic [1:0] power_mode_b_out,
    output logic amp_on_a_out,
    output logic amp_on_b_out
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] scl_sync; // [0] first stage, [1] second stage
        logic [1:0] sda_sync; // same for data line
        logic [1:0] asel_sync; // same for address select pin
        logic scl_prev; // delayed clean clock
        logic sda_prev; // delayed clean data
        bus_state_t state; // bus engine state
        bus_state_t ack_next; // state after our ack slot
        logic [3:0] cnt; // bit counter within a byte
        logic [7:0] sh; // shift register, both directions
        logic [7:0] hi_byte; // first received data byte
        logic byte_idx; // which byte of the word
        logic mst_ack; // master acked a read byte
        logic sda_oe; // we pull the data line low
        logic [1:0] ptr_sel; // stored channel selects
        logic [NUM_CH-1:0][DATA_BITS-1:0] in_reg; // input registers
        logic [NUM_CH-1:0][DATA_BITS-1:0] dac_reg; // dac registers
        logic [NUM_CH-1:0] fresh; // written since last load
        logic [NUM_CH-1:0][1:0] pmode; // power mode per channel
        logic [NUM_CH-1:0][1:0] ctl; // last clear/load bits per channel
        logic [NUM_CH-1:0][EXIT_CNT_W-1:0] wake; // power-down exit timer
        logic [NUM_CH-1:0] amp_on; // analog path enabled
    } st_t;

    st_t r; // registered state
    st_t n; // next state
    // the record is registered whole; a field keeps its value
    // unless the next-state process says otherwise

    logic scl; // clean clock level
    logic sda; // clean data level
    logic rise; // clock rising edge
    logic fall; // clock falling edge
    logic start_c; // start or repeated start
    logic stop_c; // stop condition
    logic wr_go; // write sequence completed
    logic [15:0] wr_word; // completed data word
    logic [15:0] rb_word; // word for readback
    logic [7:0] rb_byte; // next byte to send
    logic [CODE_FIELD-1:0] rb_code; // left-justified code for readback
    logic [DATA_BITS-1:0] new_code; // code field of a write

    // ------------------------------------------------------------
    // readback word
    // ------------------------------------------------------------
    // selects the channel word or the default when not exactly one
    // pointer 00 or 11 gives the default word
    // a single channel returns its dac register, not its input register
    // the control bits read back are the ones last written
    always_comb begin
        rb_code = '0;
        rb_word = READBACK_DEFAULT;
        if (r.ptr_sel == 2'b01) begin
            rb_code = CODE_FIELD'(r.dac_reg[PTR_CH_A]) << (CODE_FIELD - DATA_BITS);
            rb_word = {r.pmode[PTR_CH_A], r.ctl[PTR_CH_A], rb_code};
        end else if (r.ptr_sel == 2'b10) begin
            rb_code = CODE_FIELD'(r.dac_reg[PTR_CH_B]) << (CODE_FIELD - DATA_BITS);
            rb_word = {r.pmode[PTR_CH_B], r.ctl[PTR_CH_B], rb_code};
        end
        // byte index before toggling picks high or low half
        rb_byte = (r.state == ST_RD_ACK && !r.byte_idx) ? rb_word[7:0] : rb_word[15:8];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // bus engine, register bank and wake timers
    // the bus clock is sampled here, never used as a clock
    // edges show in the same system clock as the second stage changes
    // start and stop need the clock seen high on two samples
    // hazard: a glitch shorter than a cycle can fake a start
    always_comb begin
        n = r;
        wr_go = 1'b0;
        wr_word = '0;
        new_code = '0;
        // two-stage synchronisers, only the second stage is read
        n.scl_sync = {r.scl_sync[0], scl_in};
        n.sda_sync = {r.sda_sync[0], sda_in};
        n.asel_sync = {r.asel_sync[0], address_select_pin_in};
        scl = r.scl_sync[1];
        sda = r.sda_sync[1];
        n.scl_prev = scl;
        n.sda_prev = sda;
        rise = scl & ~r.scl_prev;
        fall = ~scl & r.scl_prev;
        start_c = scl & r.scl_prev & r.sda_prev & ~sda;
        stop_c = scl & r.scl_prev & ~r.sda_prev & sda;

        // wake timers run down to re-enable the amplifier
        // a timer only counts after a wake write
        // a new power-down write cancels a pending wake
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (r.wake[ch] != '0) begin
                n.wake[ch] = r.wake[ch] - 1'b1;
                if (r.wake[ch] == EXIT_CNT_W'(1)) begin
                    n.amp_on[ch] = 1'b1;
                end
            end
        end

        if (start_c) begin
            // start or repeated start: new address byte follows
            n.state = ST_ADDR;
            n.cnt = '0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            // stop drops any partial sequence
            n.state = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (r.state)
                ST_ADDR, ST_PTR, ST_WR: begin
                    // receive a byte, msb first, sampled on rise
                    // the eighth bit completes a byte; ack decided on the fall
                    if (rise && r.cnt != LAST_BIT_CNT) begin
                        n.sh = {r.sh[6:0], sda};
                        n.cnt = r.cnt + 1'b1;
                        if (r.state == ST_WR && r.byte_idx && r.cnt == 4'h7) begin
                            // completion at the eighth rising edge
                            wr_go = 1'b1;
                            wr_word = {r.hi_byte, r.sh[6:0], sda};
                        end
                    end else if (fall && r.cnt == LAST_BIT_CNT) begin
                        n.cnt = '0;
                        n.sda_oe = 1'b1;
                        n.state = ST_ACK;
                        if (r.state == ST_ADDR) begin
                            // own address check
                            if (r.sh[7:1] == {ADDR_UPPER, r.asel_sync[1]}) begin
                                // read direction keeps the stored pointer
                                n.ack_next = r.sh[0] ? ST_RD : ST_PTR;
                                n.byte_idx = 1'b0;
                            end else begin
                                n.sda_oe = 1'b0;
                                n.state = ST_IGNORE;
                            end
                        end else if (r.state == ST_PTR) begin
                            // one select bit per channel
                            n.ptr_sel = {r.sh[PTR_CH_B], r.sh[PTR_CH_A]};
                            n.ack_next = ST_WR;
                            n.byte_idx = 1'b0;
                        end else if (!r.byte_idx) begin
                            // first data byte held until the second arrives
                            n.hi_byte = r.sh;
                            n.byte_idx = 1'b1;
                            n.ack_next = ST_WR;
                        end else begin
                            // bytes beyond two are not taken
                            n.ack_next = ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    // release after the ninth clock, or start sending
                    // read direction loads the first byte here
                    if (fall) begin
                        n.state = r.ack_next;
                        n.cnt = '0;
                        n.sda_oe = 1'b0;
                        if (r.ack_next == ST_RD) begin
                            n.sh = rb_word[15:8];
                            n.sda_oe = ~rb_word[15];
                        end
                    end
                end
                ST_RD: begin
                    // transmit a byte, change on fall
                    // each bit is set after the fall that ends the one before
                    if (rise) begin
                        n.cnt = r.cnt + 1'b1;
                    end else if (fall && r.cnt == LAST_BIT_CNT) begin
                        n.sda_oe = 1'b0;
                        n.cnt = '0;
                        n.state = ST_RD_ACK;
                    end else if (fall && r.cnt != '0) begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.sda_oe = ~r.sh[6];
                    end
                end
                ST_RD_ACK: begin
                    // master ack keeps the word cycling
                    // no ack means the master is done reading
                    if (rise) begin
                        n.mst_ack = ~sda;
                        n.cnt = 4'h1;
                    end else if (fall && r.cnt == 4'h1) begin
                        n.cnt = '0;
                        if (r.mst_ack) begin
                            n.byte_idx = ~r.byte_idx;
                            n.sh = rb_byte;
                            n.sda_oe = ~rb_byte[7];
                            n.state = ST_RD;
                        end else begin
                            n.state = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    // wait for a start condition
                    // foreign frames also end up here
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.state = ST_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end

        // ------------------------------------------------------------
        // register bank update on a complete write
        // ------------------------------------------------------------
        // clear wins over load, so a clear never leaves stale codes
        // load low also moves the channel written by this same word
        // channels not selected keep their input register unless clear all is low
        if (wr_go) begin
            new_code = wr_word[CODE_MSB -: DATA_BITS];
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (r.ptr_sel[ch]) begin
                    n.in_reg[ch] = new_code;
                    n.fresh[ch] = 1'b1;
                    n.ctl[ch] = wr_word[CLEAR_ALL_N:SIMULTANEOUS_LOAD_N];
                    n.pmode[ch] = wr_word[POWER_MODE_HI:POWER_MODE_LO];
                    if (wr_word[POWER_MODE_HI:POWER_MODE_LO] != PM_NORMAL) begin
                        // output leaves the amplifier, dac register kept
                        n.amp_on[ch] = 1'b0;
                        n.wake[ch] = '0;
                    end else if (r.pmode[ch] != PM_NORMAL) begin
                        // 1k, 100k and open modes wake through the timer
                        n.wake[ch] = EXIT_CNT_W'(EXIT_CYCLES);
                    end
                end
            end
            if (!wr_word[SIMULTANEOUS_LOAD_N]) begin
                // simultaneous load of freshly written channels
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (n.fresh[ch]) begin
                        n.dac_reg[ch] = n.in_reg[ch];
                        n.fresh[ch] = 1'b0;
                    end
                end
            end // load bit high leaves dac registers alone unless clear all is low
            if (!wr_word[CLEAR_ALL_N]) begin
                // clear all wins over the written code
                n.in_reg = '0;
                n.dac_reg = '0;
                n.fresh = '0;
            end
        end

        // synchronous reset, idle bus lines read high
        // reset is last, so it wins over everything above
        // lines preset high so release does not look like a start
        // amplifiers come up enabled in normal mode
        if (!rst_n_in) begin
            n = '0;
            n.state = ST_IDLE;
            n.ack_next = ST_IDLE;
            n.scl_sync = 2'h3;
            n.sda_sync = 2'h3;
            n.scl_prev = 1'b1;
            n.sda_prev = 1'b1;
            n.amp_on = '1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // single register for the whole record
    always_ff @(posedge sys_clk_in) begin
        r <= n;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output except sda_out is a field of the state record
    // the data pin is open drain: only the enable moves
    assign sda_out = 1'b0; // open drain, only pulls low
    assign sda_oe_out = r.sda_oe;
    assign dac_a_code_out = r.dac_reg[PTR_CH_A];
    assign dac_b_code_out = r.dac_reg[PTR_CH_B];
    assign power_mode_a_out = r.pmode[PTR_CH_A];
    assign power_mode_b_out = r.pmode[PTR_CH_B];
    assign amp_on_a_out = r.amp_on[PTR_CH_A];
    assign amp_on_b_out = r.amp_on[PTR_CH_B];

endmodule : dual_dac_serial_control

`default_nettype wire

// ---- bench/dac_ctrl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module dac_ctrl_monitor
    import dual_dac_pkg::*;
#(
    parameter int unsigned DATA_BITS = 12
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic address_select_pin_in,
    input wire logic [DATA_BITS-1:0] dac_a_code_out,
    input wire logic [DATA_BITS-1:0] dac_b_code_out,
    input wire logic [1:0] power_mode_a_out,
    input wire logic [1:0] power_mode_b_out,
    input wire logic amp_on_a_out,
    input wire logic amp_on_b_out
);
    // ------------------------------------------------------------
    // cycles spent in normal mode, saturating
    // ------------------------------------------------------------
    logic [7:0] norm_a_r;
    logic [7:0] norm_b_r;
    always_ff @(posedge sys_clk_in) begin
        norm_a_r <= (!rst_n_in || power_mode_a_out != PM_NORMAL) ? 8'h00
            : norm_a_r + {7'h00, ~&norm_a_r};
        norm_b_r <= (!rst_n_in || power_mode_b_out != PM_NORMAL) ? 8'h00
            : norm_b_r + {7'h00, ~&norm_b_r};
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sda_zero_a: assert property (sda_out == 1'b0)
        else $error("sda data value not zero");
    oe_steady_a: assert property (scl_in [*6] |-> $stable(sda_oe_out))
        else $error("sda drive changed with bus clock high");
    amp_off_a: assert property (power_mode_a_out != PM_NORMAL |-> !amp_on_a_out)
        else $error("channel a amplifier on in power-down");
    amp_off_b: assert property (power_mode_b_out != PM_NORMAL |-> !amp_on_b_out)
        else $error("channel b amplifier on in power-down");
    wake_time_a: assert property ($rose(amp_on_a_out) |-> norm_a_r inside {[8'd124:8'd126]})
        else $error("channel a wake delay wrong");
    wake_time_b: assert property ($rose(amp_on_b_out) |-> norm_b_r inside {[8'd124:8'd126]})
        else $error("channel b wake delay wrong");
    code_quiet_a: assert property ($changed(dac_a_code_out) |-> !sda_oe_out)
        else $error("channel a code moved while device drives");
    mode_quiet_b: assert property ($changed(power_mode_b_out) |-> !sda_oe_out)
        else $error("channel b mode moved while device drives");

    ack_seen_c: cover property ($rose(sda_oe_out));
    pdown_c: cover property (power_mode_a_out == PM_OPEN);
    wake_c: cover property ($rose(amp_on_a_out));
endmodule : dac_ctrl_monitor

bind dual_dac_serial_control dac_ctrl_monitor #(.DATA_BITS(DATA_BITS)) mon_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .address_select_pin_in(address_select_pin_in),
    .dac_a_code_out(dac_a_code_out), .dac_b_code_out(dac_b_code_out),
    .power_mode_a_out(power_mode_a_out), .power_mode_b_out(power_mode_b_out),
    .amp_on_a_out(amp_on_a_out), .amp_on_b_out(amp_on_b_out));

`default_nettype wire

// ---- bench/i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    input wire logic sys_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // bus idles released, clock still between frames
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // one bit: data set in clock low, read back mid clock high
    task automatic bit_x(input logic b, output logic r);
        repeat (1) @(negedge sys_clk_in);
        sda_out = b;
        repeat (3) @(negedge sys_clk_in);
        scl_out = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        r = sda_in;
        repeat (2) @(negedge sys_clk_in);
        scl_out = 1'b0;
    endtask : bit_x

    // start or repeated start: data falls with clock high
    task automatic start();
        repeat (3) @(negedge sys_clk_in);
        sda_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        scl_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        sda_out = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        scl_out = 1'b0;
    endtask : start

    // stop: data rises with clock high
    task automatic stop();
        repeat (1) @(negedge sys_clk_in);
        sda_out = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        scl_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        sda_out = 1'b1;
        repeat (6) @(negedge sys_clk_in);
    endtask : stop

    // send a byte msb first, then sample the acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte

    // receive a byte, then acknowledge or not
    task automatic rbyte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            v[i] = r;
        end
        bit_x(~ack, r);
    endtask : rbyte
endmodule : i2c_master_model

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dual_dac_pkg::*;
    typedef struct {string nm; logic [15:0] v;} note_t;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic a0 = 1'b1;
    logic scl, m_sda, oe, dsda, amp_a, amp_b;
    logic [11:0] code_a, code_b;
    logic [1:0] pm_a, pm_b;
    wire sda_w = (oe ? dsda : 1'b1) & m_sda; // pull-up wire
    int n_errors = 0;
    int num_checks = 0;
    note_t q[$];
    logic [15:0] seen_v;
    event seen_ev;
    logic [31:0] seed = 32'hba48a52a;
    logic [11:0] in_m[2], dac_m[2];
    logic fresh[2];
    logic [1:0] pm_m[2], ctl_m[2], ptr_m = 2'b00;
    logic ack;

    always #10 sys_clk_in = ~sys_clk_in;

    dual_dac_serial_control #(.DATA_BITS(12)) dut_u (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w), .sda_out(dsda), .sda_oe_out(oe),
        .address_select_pin_in(a0), .dac_a_code_out(code_a), .dac_b_code_out(code_b),
        .power_mode_a_out(pm_a), .power_mode_b_out(pm_b), .amp_on_a_out(amp_a),
        .amp_on_b_out(amp_b));
    i2c_master_model partner_u (.sys_clk_in(sys_clk_in), .sda_in(sda_w), .scl_out(scl),
        .sda_out(m_sda));

    // random code from the shift register
    function automatic logic [11:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[11:0];
    endfunction : rnd

    task automatic compare(string nm, logic [15:0] e, logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : compare

    // driver notes the expectation, watcher compares it
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        q.push_back('{nm, e});
        seen_v = s;
        ->seen_ev;
        #1;
    endtask : chk

    always @(seen_ev) begin
        note_t n;
        n = q.pop_front();
        compare(n.nm, n.v, seen_v);
    end

    task automatic outs();
        repeat (4) @(negedge sys_clk_in);
        chk("dac_a", {4'h0, dac_m[0]}, {4'h0, code_a});
        chk("dac_b", {4'h0, dac_m[1]}, {4'h0, code_b});
        chk("mode_a", {14'h0, pm_m[0]}, {14'h0, pm_a});
        chk("mode_b", {14'h0, pm_m[1]}, {14'h0, pm_b});
    endtask : outs

    // full write and its effect on the expectation model
    task automatic wr(input logic [1:0] ptr, input logic [15:0] w);
        partner_u.start();
        partner_u.wbyte({ADDR_UPPER, a0, 1'b0}, ack);
        chk("ack_addr", 16'h1, {15'h0, ack});
        partner_u.wbyte({6'h00, ptr}, ack);
        chk("ack_ptr", 16'h1, {15'h0, ack});
        partner_u.wbyte(w[15:8], ack);
        partner_u.wbyte(w[7:0], ack);
        partner_u.stop();
        ptr_m = ptr;
        for (int c = 0; c < 2; c++) begin
            if (ptr[c]) begin
                in_m[c] = w[11:0];
                fresh[c] = 1'b1;
                pm_m[c] = w[15:14];
                ctl_m[c] = w[13:12];
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (!w[13]) begin
                in_m[c] = 12'h000;
                dac_m[c] = 12'h000;
            end else if (!w[12] && fresh[c]) dac_m[c] = in_m[c];
            if (!w[13] || !w[12]) fresh[c] = 1'b0;
        end
        outs();
    endtask : wr

    // read, with or without a fresh pointer, n words
    task automatic rd(input logic sp, input logic [1:0] ptr, input int n);
        logic [7:0] hi, lo;
        logic [15:0] e;
        if (sp) begin
            partner_u.start();
            partner_u.wbyte({ADDR_UPPER, a0, 1'b0}, ack);
            partner_u.wbyte({6'h00, ptr}, ack);
            ptr_m = ptr;
        end
        partner_u.start();
        partner_u.wbyte({ADDR_UPPER, a0, 1'b1}, ack);
        chk("ack_read", 16'h1, {15'h0, ack});
        e = ^ptr_m ? {pm_m[ptr_m[1]], ctl_m[ptr_m[1]], dac_m[ptr_m[1]]} : READBACK_DEFAULT;
        for (int i = 0; i < n; i++) begin
            partner_u.rbyte(1'b1, hi);
            partner_u.rbyte(i < n - 1, lo);
            chk("read_word", e, {hi, lo});
        end
        partner_u.stop();
    endtask : rd

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (100000) @(posedge sys_clk_in);
        n_errors++;
        print_verdict();
    end

    initial begin
        for (int c = 0; c < 2; c++) begin
            {in_m[c], dac_m[c], fresh[c], pm_m[c], ctl_m[c]} = '0;
        end
        repeat (20) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        wr(2'b01, {4'b0011, rnd()});
        rd(1'b1, 2'b01, 1);
        wr(2'b10, {4'b0010, rnd()});
        rd(1'b1, 2'b10, 3);
        rd(1'b0, 2'b00, 1);
        wr(2'b11, {4'b0010, rnd()});
        rd(1'b1, 2'b11, 1);
        for (int m = 1; m < 4; m++) begin
            wr(2'b01, {m[1:0], 2'b11, rnd()});
            chk("amp_a", 16'h0, {15'h0, amp_a});
        end
        wr(2'b01, {4'b0011, rnd()});
        chk("amp_a", 16'h0, {15'h0, amp_a});
        repeat (125) @(negedge sys_clk_in);
        chk("amp_a", 16'h1, {15'h0, amp_a});
        wr(2'b10, {4'b0101, rnd()});
        chk("amp_b", 16'h0, {15'h0, amp_b});
        partner_u.start();
        partner_u.wbyte({ADDR_UPPER, ~a0, 1'b0}, ack);
        chk("ack_foreign", 16'h0, {15'h0, ack});
        partner_u.wbyte(8'h03, ack);
        partner_u.wbyte(8'h6f, ack);
        partner_u.wbyte(8'hff, ack);
        partner_u.stop();
        outs();
        partner_u.start();
        partner_u.wbyte({ADDR_UPPER, a0, 1'b0}, ack);
        partner_u.wbyte(8'h03, ack);
        partner_u.wbyte(8'h6f, ack);
        partner_u.stop();
        outs();
        wr(2'b10, {4'b0011, rnd()});
        repeat (130) @(negedge sys_clk_in);
        chk("amp_b", 16'h1, {15'h0, amp_b});
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
